// ==== verilog/cms_pkg.sv ====
// Shared definitions for the move, branch, call, stack and system execute block.
// Assumes the fetch stage has already decoded opcodes into the operation codes below.
package cms_pkg;

	// Decoded operation handed over by the fetch and decode stage
	typedef enum logic [5:0] {
		OP_MOVE_WORD_BYTE,
		OP_MOVE_BYTE_SIGN_EXT,
		OP_MOVE_BYTE_ZERO_EXT,
		OP_JUMP_ABS_COND,
		OP_JUMP_IND_COND,
		OP_JUMP_REL_COND,
		OP_JUMP_FAR_SEGMENT,
		OP_JUMP_BIT_SET,
		OP_JUMP_BIT_CLEAR,
		OP_JUMP_TEST_CLEAR,
		OP_JUMP_TEST_SET,
		OP_CALL_ABS_COND,
		OP_CALL_IND_COND,
		OP_CALL_REL_COND,
		OP_CALL_FAR_SEGMENT,
		OP_PUSH_THEN_CALL,
		OP_TRAP_CALL,
		OP_STACK_PUSH,
		OP_STACK_POP,
		OP_CONTEXT_SWAP,
		OP_RETURN_NEAR,
		OP_RETURN_FAR,
		OP_RETURN_AND_RESTORE,
		OP_RETURN_FROM_ISR,
		OP_SOFTWARE_RESET_OP,
		OP_IDLE_ENTRY_OP,
		OP_POWER_DOWN_OP,
		OP_WATCHDOG_SERVICE_OP,
		OP_WATCHDOG_DISABLE_OP,
		OP_INIT_DONE_OP,
		OP_SEQ_START_A,
		OP_EXT_REGISTER_SEQ,
		OP_EXT_PAGE_SEQ,
		OP_EXT_SEGMENT_SEQ,
		OP_NO_OPERATION
	} cms_op_e;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_READY = 4'h1,
		ST_GAP   = 4'h2,
		ST_STEP2 = 4'h4,
		ST_HALT  = 4'h8
	} cms_st_e;

	// Instruction lengths in bytes
	localparam logic [2:0] LEN_SHORT  = 3'h2;
	localparam logic [2:0] LEN_LONG   = 3'h4;
	localparam int         LEN_W      = 3;
	// Byte field layout
	localparam int         BYTE_W     = 8;
	localparam int         BYTE_MSB   = 7;
	// Trap vectors sit four bytes apart
	localparam int         TRAP_SHIFT = 2;
	localparam int         TRAP_W     = 7;
	// Prefix range field, sequence counter and mode pin sync depth
	localparam int         EXTCNT_W   = 2;
	localparam int         SEQ_W      = 3;
	localparam int         SYNC_N     = 3;

endpackage

// ==== verilog/cms_exec.sv ====
// Execute unit for moves, branches, call_far_segment, stack ops, returns, system ops and prefixes.
// Assumes the pipeline decodes opcodes, evaluates conditions and presents the stack top.
// Function
// - Move copies word or byte, 2/4 bytes
// - Byte move sign-extends into upper byte
// - Byte move zero-extends into upper byte
// - Conditional jumps branch only when condition true
// - Far jump loads segment and absolute target
// - Bit jumps branch on set or clear
// - Test-clear jump branches and clears set bit
// - Test-set jump branches and sets clear bit
// - Conditional calls save return, branch when true
// - Far call saves segment and return address
// - Push register first, then absolute call
// - Trap enters vector chosen by trap number
// - Push and pop move register via stack
// - Context swap pushes register, then loads operand
// - Near, far and interrupt returns pop stack
// - Return also restores register from stack
// - Power down only with mode input low
// - Init done releases the reset output pin
// - Page prefix starts explicit-page instruction sequence
// - Segment prefix starts explicit-segment instruction sequence
`timescale 1ns/1ps

module cms_exec
	import cms_pkg::*;
#(
	parameter int DW = 16,
	parameter int SW = 8
) (
	// Clock, reset, enable
	input  wire logic          mclk,
	input  wire logic          rst_b,
	input  wire logic          ce,
	// Decoded instruction from the pipeline
	input  wire logic          instr_valid,
	input  wire cms_op_e       instr_op,
	input  wire logic          long_form,
	input  wire logic          cond_true,
	input  wire logic          byte_op,
	input  wire logic [DW-1:0] src_data,
	input  wire logic          bit_val,
	input  wire logic [DW-1:0] target_addr,
	input  wire logic [SW-1:0] target_seg,
	input  wire logic [DW-1:0] ret_pc,
	input  wire logic [SW-1:0] cur_seg,
	input  wire logic [DW-1:0] reg_old,
	input  wire logic [DW-1:0] stack_data,
	input  wire logic [TRAP_W-1:0] trap_num,
	input  wire logic [EXTCNT_W-1:0] ext_count,
	input  wire logic          ext_with_reg,
	input  wire logic          wake_req,
	// Pin
	input  wire logic          power_down_mode_input,
	// Handshake and length
	output logic               instr_ready_q,
	output logic [LEN_W-1:0]   instr_len_q,
	// Destination write
	output logic               dst_we_q,
	output logic               dst_byte_q,
	output logic [DW-1:0]      dst_data_q,
	// Control transfer
	output logic               branch_q,
	output logic [DW-1:0]      pc_q,
	output logic               seg_load_q,
	output logic [SW-1:0]      seg_q,
	output logic               trap_q,
	// Stack
	output logic               push_q,
	output logic [DW-1:0]      push_data_q,
	output logic               pop_q,
	// Direct bit write-back
	output logic               bit_we_q,
	output logic               bit_data_q,
	// System side effects
	output logic               soft_reset_q,
	output logic               idle_q,
	output logic               power_down_q,
	output logic               wdt_service_q,
	output logic               wdt_disable_q,
	output logic               reset_output_pin_b_q,
	// Prefix sequence state
	output logic               ext_page_q,
	output logic               ext_seg_q,
	output logic               ext_reg_q,
	output logic               seq_start_a_q
);

	typedef struct packed {
		cms_st_e          state;
		logic             ready;
		logic [LEN_W-1:0] len;
		logic             dst_we;
		logic             dst_byte;
		logic [DW-1:0]    dst_data;
		logic             branch;
		logic [DW-1:0]    pc;
		logic             seg_load;
		logic [SW-1:0]    seg;
		logic             trap;
		logic             push;
		logic [DW-1:0]    push_data;
		logic             pop;
		logic             bit_we;
		logic             bit_data;
		logic             soft_reset;
		logic             idle;
		logic             pdown;
		logic             wdt_srv;
		logic             wdt_dis;
		logic             reset_output_pin_b;
		logic             ext_page;
		logic             ext_seg;
		logic             ext_reg;
		logic             seq_start_a;
		logic [SEQ_W-1:0] seq_cnt;
		cms_op_e          lat_op;
		logic [DW-1:0]    lat_ret;
		logic [DW-1:0]    lat_tgt;
		logic [SW-1:0]    lat_seg;
		logic [DW-1:0]    lat_data;
		logic [SYNC_N-1:0] sync;
		logic             mmi_lvl;
	} cms_state_s;

	cms_state_s q;
	cms_state_s n;

	// Length in bytes of each operation; variable forms pick by long_form
	function automatic logic [LEN_W-1:0] op_len(input cms_op_e op, input logic lng);
		logic [LEN_W-1:0] l;
		l = LEN_LONG;
		unique case (op)
			OP_MOVE_WORD_BYTE, OP_MOVE_BYTE_SIGN_EXT, OP_MOVE_BYTE_ZERO_EXT,
			OP_EXT_PAGE_SEQ, OP_EXT_SEGMENT_SEQ:
				l = lng ? LEN_LONG : LEN_SHORT;
			OP_TRAP_CALL, OP_STACK_PUSH, OP_STACK_POP, OP_RETURN_NEAR, OP_RETURN_FAR,
			OP_RETURN_AND_RESTORE, OP_RETURN_FROM_ISR, OP_SEQ_START_A,
			OP_EXT_REGISTER_SEQ, OP_NO_OPERATION:
				l = LEN_SHORT;
			default:
				l = LEN_LONG;
		endcase
		return l;
	endfunction

	// Trap entry address: vectors sit four bytes apart from address zero
	function automatic logic [DW-1:0] trap_vector(input logic [TRAP_W-1:0] num);
		return DW'({num, {TRAP_SHIFT{1'b0}}});
	endfunction

	always_comb begin
		n = q;
		n.dst_we     = 1'b0;
		n.branch     = 1'b0;
		n.seg_load   = 1'b0;
		n.trap       = 1'b0;
		n.push       = 1'b0;
		n.pop        = 1'b0;
		n.bit_we     = 1'b0;
		n.soft_reset = 1'b0;
		n.wdt_srv    = 1'b0;
		n.wdt_dis    = 1'b0;
		// Mode pin counts only once two late sync stages agree
		n.sync = {q.sync[SYNC_N-2:0], power_down_mode_input};
		if (q.sync[SYNC_N-1] == q.sync[SYNC_N-2]) begin
			n.mmi_lvl = q.sync[SYNC_N-1];
		end
		unique case (q.state)
			ST_READY: begin
				if (instr_valid && q.ready) begin
					n.len      = op_len(instr_op, long_form);
					n.lat_op   = instr_op;
					n.lat_ret  = ret_pc;
					n.lat_tgt  = target_addr;
					n.lat_seg  = target_seg;
					n.lat_data = src_data;
					// Prefix scope counts down over the instructions that follow it
					if (q.seq_cnt != '0) begin
						n.seq_cnt = q.seq_cnt - SEQ_W'(1);
						if (q.seq_cnt == SEQ_W'(1)) begin
							n.ext_page = 1'b0;
							n.ext_seg  = 1'b0;
							n.ext_reg  = 1'b0;
							n.seq_start_a   = 1'b0;
						end
					end
					unique case (instr_op)
						OP_MOVE_WORD_BYTE: begin
							n.dst_we   = 1'b1;
							n.dst_byte = byte_op;
							n.dst_data = byte_op ? DW'(src_data[BYTE_MSB:0]) : src_data;
						end
						OP_MOVE_BYTE_SIGN_EXT: begin
							n.dst_we   = 1'b1;
							n.dst_byte = 1'b0;
							n.dst_data = {{(DW-BYTE_W){src_data[BYTE_MSB]}},
								src_data[BYTE_MSB:0]};
						end
						OP_MOVE_BYTE_ZERO_EXT: begin
							n.dst_we   = 1'b1;
							n.dst_byte = 1'b0;
							n.dst_data = {{(DW-BYTE_W){1'b0}}, src_data[BYTE_MSB:0]};
						end
						OP_JUMP_ABS_COND, OP_JUMP_IND_COND, OP_JUMP_REL_COND: begin
							n.branch = cond_true;
							n.pc     = target_addr;
						end
						OP_JUMP_FAR_SEGMENT: begin
							n.branch   = 1'b1;
							n.pc       = target_addr;
							n.seg_load = 1'b1;
							n.seg      = target_seg;
						end
						OP_JUMP_BIT_SET, OP_JUMP_BIT_CLEAR: begin
							n.branch = bit_val ^ (instr_op == OP_JUMP_BIT_CLEAR);
							n.pc     = target_addr;
						end
						OP_JUMP_TEST_CLEAR: begin
							// Branch and clear land in the same cycle so nothing slips between
							n.branch   = bit_val;
							n.bit_we   = bit_val;
							n.bit_data = 1'b0;
							n.pc       = target_addr;
						end
						OP_JUMP_TEST_SET: begin
							n.branch   = !bit_val;
							n.bit_we   = !bit_val;
							n.bit_data = 1'b1;
							n.pc       = target_addr;
						end
						OP_CALL_ABS_COND, OP_CALL_IND_COND, OP_CALL_REL_COND: begin
							n.push      = cond_true;
							n.push_data = ret_pc;
							n.branch    = cond_true;
							n.pc        = target_addr;
						end
						OP_CALL_FAR_SEGMENT: begin
							n.push      = 1'b1;
							n.push_data = DW'(cur_seg);
							n.state     = ST_GAP;
						end
						OP_PUSH_THEN_CALL, OP_CONTEXT_SWAP: begin
							n.push      = 1'b1;
							n.push_data = reg_old;
							n.state     = ST_GAP;
						end
						OP_TRAP_CALL: begin
							n.trap      = 1'b1;
							n.push      = 1'b1;
							n.push_data = ret_pc;
							n.branch    = 1'b1;
							n.pc        = trap_vector(trap_num);
						end
						OP_STACK_PUSH: begin
							n.push      = 1'b1;
							n.push_data = reg_old;
						end
						OP_STACK_POP: begin
							n.pop      = 1'b1;
							n.dst_we   = 1'b1;
							n.dst_byte = 1'b0;
							n.dst_data = stack_data;
						end
						OP_RETURN_NEAR: begin
							n.pop    = 1'b1;
							n.branch = 1'b1;
							n.pc     = stack_data;
						end
						OP_RETURN_FAR, OP_RETURN_FROM_ISR, OP_RETURN_AND_RESTORE: begin
							n.pop    = 1'b1;
							n.branch = 1'b1;
							n.pc     = stack_data;
							n.state  = ST_GAP;
						end
						OP_SOFTWARE_RESET_OP: n.soft_reset = 1'b1;
						OP_IDLE_ENTRY_OP: begin
							n.idle  = 1'b1;
							n.state = ST_HALT;
						end
						OP_POWER_DOWN_OP: begin
							// With the mode pin high the op falls through as a no-op
							if (!q.mmi_lvl) begin
								n.pdown = 1'b1;
								n.state = ST_HALT;
							end
						end
						OP_WATCHDOG_SERVICE_OP: n.wdt_srv = 1'b1;
						OP_WATCHDOG_DISABLE_OP: n.wdt_dis = 1'b1;
						OP_INIT_DONE_OP: n.reset_output_pin_b = 1'b1;
						OP_SEQ_START_A: begin
							n.seq_start_a  = 1'b1;
							n.seq_cnt = SEQ_W'(ext_count) + SEQ_W'(1);
						end
						OP_EXT_REGISTER_SEQ: begin
							n.ext_reg = 1'b1;
							n.seq_cnt = SEQ_W'(ext_count) + SEQ_W'(1);
						end
						OP_EXT_PAGE_SEQ: begin
							n.ext_page = 1'b1;
							n.ext_seg  = 1'b0;
							n.ext_reg  = ext_with_reg;
							n.seq_cnt  = SEQ_W'(ext_count) + SEQ_W'(1);
						end
						OP_EXT_SEGMENT_SEQ: begin
							n.ext_seg  = 1'b1;
							n.ext_page = 1'b0;
							n.ext_reg  = ext_with_reg;
							n.seq_cnt  = SEQ_W'(ext_count) + SEQ_W'(1);
						end
						OP_NO_OPERATION: n.len = LEN_SHORT;
						default: n.len = op_len(instr_op, long_form);
					endcase
				end
			end
			// One spare cycle so the partner can act on the first push or pop
			ST_GAP: n.state = ST_STEP2;
			ST_STEP2: begin
				n.state = ST_READY;
				unique case (q.lat_op)
					OP_CALL_FAR_SEGMENT, OP_PUSH_THEN_CALL: begin
						n.push      = 1'b1;
						n.push_data = q.lat_ret;
						n.branch    = 1'b1;
						n.pc        = q.lat_tgt;
						n.seg_load  = (q.lat_op == OP_CALL_FAR_SEGMENT);
						n.seg       = q.lat_seg;
					end
					OP_CONTEXT_SWAP: begin
						n.dst_we   = 1'b1;
						n.dst_byte = 1'b0;
						n.dst_data = q.lat_data;
					end
					OP_RETURN_FAR, OP_RETURN_FROM_ISR: begin
						n.pop      = 1'b1;
						n.seg_load = 1'b1;
						n.seg      = stack_data[SW-1:0];
					end
					OP_RETURN_AND_RESTORE: begin
						n.pop      = 1'b1;
						n.dst_we   = 1'b1;
						n.dst_byte = 1'b0;
						n.dst_data = stack_data;
					end
					default: n.state = ST_READY;
				endcase
			end
			ST_HALT: begin
				// Power down leaves only through reset
				if (q.idle && wake_req) begin
					n.idle  = 1'b0;
					n.state = ST_READY;
				end
			end
			default: n.state = ST_READY;
		endcase
		n.ready = (n.state == ST_READY);
	end

	// Enable gates reset too, so a frozen block keeps every bit
	always_ff @(posedge mclk) begin
		if (ce) begin
			if (!rst_b) begin
				q          <= '0;
				q.state    <= ST_READY;
				q.ready    <= 1'b1;
				q.len      <= LEN_SHORT;
				q.lat_op   <= OP_NO_OPERATION;
				q.sync     <= '1;
				q.mmi_lvl  <= 1'b1;
			end else begin
				q <= n;
			end
		end
	end

	assign instr_ready_q        = q.ready;
	assign instr_len_q          = q.len;
	assign dst_we_q             = q.dst_we;
	assign dst_byte_q           = q.dst_byte;
	assign dst_data_q           = q.dst_data;
	assign branch_q             = q.branch;
	assign pc_q                 = q.pc;
	assign seg_load_q           = q.seg_load;
	assign seg_q                = q.seg;
	assign trap_q               = q.trap;
	assign push_q               = q.push;
	assign push_data_q          = q.push_data;
	assign pop_q                = q.pop;
	assign bit_we_q             = q.bit_we;
	assign bit_data_q           = q.bit_data;
	assign soft_reset_q         = q.soft_reset;
	assign idle_q               = q.idle;
	assign power_down_q         = q.pdown;
	assign wdt_service_q        = q.wdt_srv;
	assign wdt_disable_q        = q.wdt_dis;
	assign reset_output_pin_b_q = q.reset_output_pin_b;
	assign ext_page_q           = q.ext_page;
	assign ext_seg_q            = q.ext_seg;
	assign ext_reg_q            = q.ext_reg;
	assign seq_start_a_q             = q.seq_start_a;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	logic take;
	assign take = instr_valid && instr_ready_q && ce;

	a_move_length: assert property (
		take && instr_op == OP_MOVE_WORD_BYTE
		|=> instr_len_q == ($past(long_form) ? LEN_LONG : LEN_SHORT) && dst_we_q)
		else $error("move length or write wrong");
	a_sign_extend: assert property (
		take && instr_op == OP_MOVE_BYTE_SIGN_EXT
		|=> dst_data_q[DW-1:BYTE_W] == {(DW-BYTE_W){$past(src_data[BYTE_MSB])}})
		else $error("sign extension wrong");
	a_zero_extend: assert property (
		take && instr_op == OP_MOVE_BYTE_ZERO_EXT
		|=> dst_data_q[DW-1:BYTE_W] == '0 && dst_data_q[BYTE_MSB:0] == $past(src_data[BYTE_MSB:0]))
		else $error("zero extension wrong");
	a_cond_jump: assert property (
		take && instr_op == OP_JUMP_REL_COND
		|=> branch_q == $past(cond_true) && instr_len_q == LEN_LONG)
		else $error("conditional jump wrong");
	a_test_clear: assert property (
		take && instr_op == OP_JUMP_TEST_CLEAR
		|=> bit_we_q == $past(bit_val) && branch_q == $past(bit_val) && !bit_data_q)
		else $error("test and clear jump wrong");
	a_test_set: assert property (
		take && instr_op == OP_JUMP_TEST_SET
		|=> bit_we_q == !$past(bit_val) && branch_q == !$past(bit_val) && bit_data_q)
		else $error("test and set jump wrong");
	a_trap_vector: assert property (
		take && instr_op == OP_TRAP_CALL
		|=> trap_q && push_q && pc_q == trap_vector($past(trap_num)))
		else $error("trap vector wrong");
	a_push_call: assert property (
		take && instr_op == OP_PUSH_THEN_CALL
		|=> push_q && !branch_q ##1 !push_q ##1 push_q && branch_q)
		else $error("push then call order wrong");
	a_pdown_gate: assert property (
		$rose(power_down_q) |-> $past(q.mmi_lvl) == 1'b0)
		else $error("power down entered with mode input high");
	a_init_pin: assert property (
		take && instr_op == OP_INIT_DONE_OP |=> reset_output_pin_b_q)
		else $error("reset output pin not released");

endmodule

// ==== tb/cms_stack_model.sv ====
// Behavioural system stack that stands in the pipeline's place.
// Assumes push and pop are one-cycle pulses that never coincide.
`timescale 1ns/1ps
module cms_stack_model (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// Requests from the execute unit
	input  wire logic        push,
	input  wire logic [15:0] push_data,
	input  wire logic        pop,
	// Current top word
	output logic [15:0]      stack_data
);
	logic [15:0] mem [16];
	logic [3:0]  sp;

	// Empty stack shows inverted stale data so a stray pop is not masked
	assign stack_data = (sp == 4'h0) ? ~mem[0] : mem[sp - 4'h1];

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sp <= 4'h0;
		end else if (push) begin
			mem[sp] <= push_data;
			sp      <= sp + 4'h1;
		end else if (pop) begin
			sp <= sp - 4'h1;
		end
	end
endmodule

// ==== tb/cms_exec_tb_top.sv ====
// Self-checking bench for the execute unit: random operands plus fixed sequences.
// Assumes the behavioural stack model on the far side and a 50 MHz clock.
`timescale 1ns/1ps
module cms_exec_tb_top;
	import cms_pkg::*;
	logic        mclk, rst_b, ce, instr_valid, long_form, cond_true, byte_op, bit_val;
	logic        ext_with_reg, wake_req, mode_pin, e;
	cms_op_e     instr_op;
	logic [15:0] src_data, target_addr, ret_pc, reg_old, stack_data, lfsr, sv_a, sv_b;
	logic [7:0]  target_seg, cur_seg, seg;
	logic [6:0]  trap_num;
	logic [1:0]  ext_count;
	logic        rdy, dwe, dby, br, sld, trp, psh, pop, bwe, bdat, software_reset_op, idl, pdn, wsv, wds;
	logic        rpin_b, xpg, xsg, xrg, atm;
	logic [2:0]  len;
	logic [15:0] ddat, pc, pdat;
	int          n_fail, num_checks, w, i, j, k;
	cms_op_e     mv_ops [3] = '{OP_MOVE_WORD_BYTE, OP_MOVE_BYTE_SIGN_EXT, OP_MOVE_BYTE_ZERO_EXT};
	cms_op_e     jp_ops [10] = '{OP_JUMP_ABS_COND, OP_JUMP_IND_COND, OP_JUMP_REL_COND,
		OP_JUMP_BIT_SET, OP_JUMP_BIT_CLEAR, OP_JUMP_TEST_CLEAR, OP_JUMP_TEST_SET,
		OP_CALL_ABS_COND, OP_CALL_IND_COND, OP_CALL_REL_COND};
	cms_op_e     sy_ops [6] = '{OP_SOFTWARE_RESET_OP, OP_WATCHDOG_SERVICE_OP,
		OP_WATCHDOG_DISABLE_OP, OP_SEQ_START_A, OP_EXT_REGISTER_SEQ, OP_NO_OPERATION};
	logic [15:0] sy_len [6] = '{16'h4, 16'h4, 16'h4, 16'h2, 16'h2, 16'h2};

	cms_exec u_dut (
		.mclk(mclk), .rst_b(rst_b), .ce(ce), .instr_valid(instr_valid), .instr_op(instr_op),
		.long_form(long_form), .cond_true(cond_true), .byte_op(byte_op), .src_data(src_data),
		.bit_val(bit_val), .target_addr(target_addr), .target_seg(target_seg), .ret_pc(ret_pc),
		.cur_seg(cur_seg), .reg_old(reg_old), .stack_data(stack_data), .trap_num(trap_num),
		.ext_count(ext_count), .ext_with_reg(ext_with_reg), .wake_req(wake_req),
		.power_down_mode_input(mode_pin), .instr_ready_q(rdy), .instr_len_q(len),
		.dst_we_q(dwe), .dst_byte_q(dby), .dst_data_q(ddat), .branch_q(br), .pc_q(pc),
		.seg_load_q(sld), .seg_q(seg), .trap_q(trp), .push_q(psh), .push_data_q(pdat),
		.pop_q(pop), .bit_we_q(bwe), .bit_data_q(bdat), .soft_reset_q(software_reset_op), .idle_q(idl),
		.power_down_q(pdn), .wdt_service_q(wsv), .wdt_disable_q(wds),
		.reset_output_pin_b_q(rpin_b), .ext_page_q(xpg), .ext_seg_q(xsg), .ext_reg_q(xrg),
		.seq_start_a_q(atm)
	);
	cms_stack_model u_stack (.mclk(mclk), .rst_b(rst_b), .push(psh), .push_data(pdat),
		.pop(pop), .stack_data(stack_data));

	always #10 mclk = ~mclk;

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Byte forms keep only the low byte of the source
	function automatic logic [15:0] exp_mv(input cms_op_e op, input logic b, input logic [15:0] s);
		if (op == OP_MOVE_BYTE_SIGN_EXT) return {{8{s[7]}}, s[7:0]};
		if (op == OP_MOVE_WORD_BYTE && !b) return s;
		return {8'h00, s[7:0]};
	endfunction

	function automatic logic exp_br(input cms_op_e op, input logic c, input logic b);
		case (op)
			OP_JUMP_BIT_SET, OP_JUMP_TEST_CLEAR: return b;
			OP_JUMP_BIT_CLEAR, OP_JUMP_TEST_SET: return !b;
			default: return c;
		endcase
	endfunction

	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rnd();
		lfsr = lfsr_next(lfsr);
		src_data    <= lfsr;
		target_addr <= {lfsr[7:0], lfsr[15:8]};
		ret_pc      <= ~lfsr;
		reg_old     <= lfsr ^ 16'h5a3c;
		target_seg  <= lfsr[11:4];
		cur_seg     <= lfsr[15:8];
		trap_num    <= lfsr[6:0];
		{cond_true, bit_val, byte_op, long_form, ext_with_reg, ext_count} <= lfsr[13:7];
	endtask

	// Called in a rising-edge step; returns at the edge that takes the instruction
	task automatic take(input cms_op_e op, input logic hold);
		int n;
		n = 0;
		instr_op    <= op;
		instr_valid <= 1'b1;
		@(negedge mclk);
		while (rdy !== 1'b1 && n < 50) begin
			n++;
			@(negedge mclk);
		end
		if (n == 50) n_fail++;
		w = n;
		@(posedge mclk);
		if (!hold) instr_valid <= 1'b0;
	endtask

	// Ends at the falling edge of the first cycle after the take
	task automatic run(input cms_op_e op);
		@(posedge mclk);
		rnd();
		take(op, 1'b0);
		@(negedge mclk);
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		finish_test();
	end

	initial begin
		mclk        = 1'b0;
		rst_b       = 1'b0;
		ce          = 1'b1;
		instr_valid = 1'b0;
		instr_op    = OP_NO_OPERATION;
		wake_req    = 1'b0;
		mode_pin    = 1'b1;
		lfsr        = 16'h000b;
		n_fail      = 0;
		num_checks  = 0;
		rnd();
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		@(negedge mclk);
		chk_bit(rdy, 1'b1);
		chk_bit(rpin_b | pdn | idl | xpg | xsg | xrg | atm, 1'b0);
		for (i = 0; i < 12; i++) begin
			run(mv_ops[i % 3]);
			chk_bit(dwe, 1'b1);
			chk_val(ddat, exp_mv(mv_ops[i % 3], byte_op, src_data));
			chk_val(16'(len), long_form ? 16'h4 : 16'h2);
			if (i % 3 == 0) chk_bit(dby, byte_op);
		end
		// Two moves back to back: the second must be taken at once
		@(posedge mclk);
		rnd();
		take(OP_MOVE_WORD_BYTE, 1'b1);
		rnd();
		take(OP_MOVE_BYTE_ZERO_EXT, 1'b0);
		chk_bit(w == 0, 1'b1);
		@(negedge mclk);
		chk_val(ddat, {8'h00, src_data[7:0]});
		for (i = 0; i < 40; i++) begin
			run(jp_ops[i % 10]);
			e = exp_br(jp_ops[i % 10], cond_true, bit_val);
			chk_bit(br, e);
			if (e) chk_val(pc, target_addr);
			chk_val(16'(len), 16'h4);
			if (i % 10 == 5 || i % 10 == 6) chk_bit(bwe, e);
			if (e && (i % 10 == 5 || i % 10 == 6)) chk_bit(bdat, i % 10 == 6);
			if (i % 10 > 6) chk_bit(psh, e);
			if (e && i % 10 > 6) chk_val(pdat, ret_pc);
		end
		run(OP_JUMP_FAR_SEGMENT);
		chk_bit(br & sld, 1'b1);
		chk_val(pc, target_addr);
		chk_val({8'h00, seg}, {8'h00, target_seg});
		chk_val(16'(len), 16'h4);
		for (i = 0; i < 2; i++) begin
			run(OP_CALL_FAR_SEGMENT);
			sv_a = ret_pc;
			sv_b = {8'h00, cur_seg};
			chk_bit(psh, 1'b1);
			chk_val(pdat, sv_b);
			chk_bit(rdy, 1'b0);
			@(negedge mclk);
			chk_bit(psh, 1'b0);
			@(negedge mclk);
			chk_val(pdat, sv_a);
			chk_bit(br & sld & psh & rdy, 1'b1);
			chk_val(pc, target_addr);
			chk_val({8'h00, seg}, {8'h00, target_seg});
			run(i ? OP_RETURN_FROM_ISR : OP_RETURN_FAR);
			chk_bit(pop & br, 1'b1);
			chk_val(pc, sv_a);
			repeat (2) @(negedge mclk);
			chk_bit(pop & sld, 1'b1);
			chk_val({8'h00, seg}, sv_b);
			chk_val(16'(len), 16'h2);
		end
		run(OP_PUSH_THEN_CALL);
		sv_a = ret_pc;
		sv_b = reg_old;
		chk_val({15'h0000, psh}, 16'h1);
		chk_val(pdat, reg_old);
		repeat (2) @(negedge mclk);
		chk_bit(br, 1'b1);
		chk_val(pc, target_addr);
		run(OP_RETURN_AND_RESTORE);
		chk_bit(pop & br, 1'b1);
		chk_val(pc, sv_a);
		repeat (2) @(negedge mclk);
		chk_bit(pop, 1'b1);
		chk_bit(dwe, 1'b1);
		chk_val(ddat, sv_b);
		chk_val(16'(len), 16'h2);
		run(OP_CONTEXT_SWAP);
		sv_a = src_data;
		sv_b = reg_old;
		chk_bit(psh, 1'b1);
		chk_val(pdat, reg_old);
		repeat (2) @(negedge mclk);
		chk_val(ddat, sv_a);
		chk_val(16'(len), 16'h4);
		run(OP_STACK_PUSH);
		sv_a = reg_old;
		chk_bit(psh, 1'b1);
		chk_val(pdat, sv_a);
		run(OP_RETURN_NEAR);
		chk_bit(pop & br, 1'b1);
		chk_val(pc, sv_a);
		run(OP_STACK_POP);
		chk_bit(pop, 1'b1);
		chk_val(ddat, sv_b);
		chk_val(16'(len), 16'h2);
		run(OP_TRAP_CALL);
		chk_bit(trp, 1'b1);
		chk_val(pc, {7'h00, trap_num, 2'b00});
		chk_val(16'(len), 16'h2);
		for (i = 0; i < 6; i++) begin
			run(sy_ops[i]);
			chk_val(16'(len), sy_len[i]);
			chk_val({software_reset_op, wsv, wds}, {i == 0, i == 1, i == 2});
			if (i == 3) chk_bit(atm, 1'b1);
			if (i == 4) chk_bit(xrg, 1'b1);
		end
		// With the enable low a pulse must stand until the enable returns
		@(posedge mclk);
		take(OP_SOFTWARE_RESET_OP, 1'b0);
		ce <= 1'b0;
		repeat (3) @(negedge mclk);
		chk_bit(software_reset_op, 1'b1);
		@(posedge mclk);
		ce <= 1'b1;
		repeat (2) @(negedge mclk);
		chk_bit(software_reset_op, 1'b0);
		for (j = 0; j < 4; j++) begin
			run(j[0] ? OP_EXT_SEGMENT_SEQ : OP_EXT_PAGE_SEQ);
			k = ext_count;
			chk_bit(j[0] ? xsg : xpg, 1'b1);
			chk_bit(xrg, ext_with_reg);
			chk_val(16'(len), long_form ? 16'h4 : 16'h2);
			for (i = 0; i <= k; i++) begin
				run(OP_NO_OPERATION);
				chk_bit(xpg | xsg, i < k);
			end
		end
		run(OP_IDLE_ENTRY_OP);
		chk_bit(idl, 1'b1);
		chk_val(16'(len), 16'h4);
		// An offer made while idle must be ignored
		@(posedge mclk);
		instr_op    <= OP_INIT_DONE_OP;
		instr_valid <= 1'b1;
		repeat (3) @(negedge mclk);
		chk_bit(rdy | rpin_b, 1'b0);
		@(posedge mclk);
		wake_req <= 1'b1;
		take(OP_INIT_DONE_OP, 1'b0);
		@(negedge mclk);
		chk_bit(rpin_b, 1'b1);
		chk_bit(idl, 1'b0);
		@(posedge mclk);
		wake_req <= 1'b0;
		run(OP_POWER_DOWN_OP);
		chk_bit(pdn, 1'b0);
		chk_val(16'(len), 16'h4);
		@(posedge mclk);
		mode_pin <= 1'b0;
		repeat (4) @(posedge mclk);
		run(OP_POWER_DOWN_OP);
		chk_bit(pdn, 1'b1);
		repeat (3) @(negedge mclk);
		chk_bit(rdy, 1'b0);
		@(posedge mclk);
		rst_b    <= 1'b0;
		mode_pin <= 1'b1;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		@(negedge mclk);
		chk_bit(pdn | rpin_b, 1'b0);
		chk_bit(rdy, 1'b1);
		finish_test();
	end
endmodule
